// ---- verilog/led_dim_map.svh ----
/*
 Register indices, field positions, reset values, levels and timing
 figures of the LED dimming and converter sequencing block.
 Assumes a 125 MHz aclk; indices are word indices (byte address = 4*index).
*/
`ifndef LED_DIM_MAP_SVH
`define LED_DIM_MAP_SVH

// Register word indices
`define IDX_MODE 8'h00
`define IDX_FREQ 8'h01
`define IDX_DIM_LO 8'h03
`define IDX_DIM_HI 8'h04
`define IDX_STATUS 8'h07

// Field positions
`define MODE_METHOD_LSB 0
`define MODE_INTERNAL_BIT 2
`define MODE_STRING_LSB 4
`define FREQ_SEL_LSB 0
`define DIM_LO_LSB 0
`define STAT_STATE_LSB 0
`define STAT_GATE_BIT 3
`define STAT_STRING_LSB 4
`define STAT_LEVEL_LSB 8

// Reset values
`define RST_METHOD 2'h0
`define RST_INTERNAL 1'h0
`define RST_STRINGS 4'hf
`define RST_FREQ 4'h0
`define RST_DIM 10'h3ff

// Dimming levels on a 10-bit scale
`define LEVEL_FULL 10'h3ff
`define LEVEL_MIX25 10'h100
`define LEVEL_MIX50 10'h200
`define LEVEL_LOW_CUT 10'h00d

// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Timing
`define CLK_HZ 125000000
`define CLK_KHZ 125000
`define CLK_PERIOD_NS 8
`define DIM_FREQ_HZ 23000
`define MIN_PULSE_NS 2000
`define MIN_ON_NS 150
`define SOFT_START_US 1000
`define FS_MIN_KHZ 100
`define FS_MAX_KHZ 900
`define FS_STEPS 15
`define RATIO_SHIFT 16

`endif

// ---- verilog/led_dim_pkg.sv ----
/*
 Types of the LED dimming and converter sequencing block.
 Assumes nothing of its surroundings.
*/
package led_dim_pkg;

    // Start-up sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OVP_CHECK = 3'b001,
        ST_SAFETY = 3'b010,
        ST_SOFT_START = 3'b011,
        ST_RUN = 3'b100
    } start_state_e;

    // Dimming method field
    typedef enum logic [1:0] {
        METH_PWM = 2'b00,
        METH_ANALOG = 2'b01,
        METH_MIX25 = 2'b10,
        METH_MIX50 = 2'b11
    } dim_method_e;

    typedef logic [9:0] level_t;

endpackage

// ---- verilog/led_dimming_mode_control.sv ----
/*
 LED dimming mode control: AXI4-Lite register slave, brightness
 measurement, dimming waveform, start-up sequencing and boost switch
 timing. Assumes analog comparators deliver clean levels synchronous
 to aclk and that string sink levels arrive as 8-bit codes.
*/
`timescale 1ns/1ns
`include "led_dim_map.svh"

// Operation
// - PWM method, external source: string current follows brightness pin.
// - PWM method, internal source: duty comes from dimming value.
// - Internal dimming waveform runs at fixed 23 kHz.
// - Analog method, external: amplitude follows measured input duty.
// - Analog method, internal: amplitude follows dimming value.
// - Method 10b: analog above 25 percent, duty dimming at or below.
// - Method 11b: analog above 50 percent, duty dimming at or below.
// - Mixed external below transfer point: full amplitude, duty equals ratio.
// - Mixed internal: amplitude and duty both from dimming value.
// - Mixed below transfer point pulses at 23 kHz for either source.
// - Analog and mixed: strings off below 1.2 percent of full scale.
// - External analog and mixed: input pulses narrower than 2 us rejected.
// - Switching frequency from four select bits, 100 to 900 kHz.
// - After enable, switching only once overvoltage sense exceeds 2.5 V.
// - Then string, supply, temperature, current checks; soft start if clear.
// - Switch on at each cycle start where boost is requested, held at least 150 ns.
// - Light load: minimum pulses, then off until boost is needed.
// - Regulate against lowest level among enabled string sinks.
// - External analog and mixed: input duty averaged to set current.
// - Internal bit is bit 2, method bits 1:0 of register 00H.
module led_dimming_mode_control
    import led_dim_pkg::*;
#(
    parameter int DIM_PERIOD_CYC = `CLK_HZ / `DIM_FREQ_HZ,
    parameter int SOFT_START_CYC = `SOFT_START_US * 1000 / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Enable and brightness input
    input wire logic enable,
    input wire logic pwm_in,
    // Start-up checks, high means the condition is present
    input wire logic output_overvoltage_sense,
    input wire logic string_fault,
    input wire logic supply_undervoltage_lockout,
    input wire logic over_temp,
    input wire logic switch_overcurrent_protection,
    // Converter loop comparators
    input wire logic switch_current_sense,
    input wire logic light_load,
    input wire logic boost_request,
    // String sink levels
    input wire logic [7:0] string_sink_pin0,
    input wire logic [7:0] string_sink_pin1,
    input wire logic [7:0] string_sink_pin2,
    input wire logic [7:0] string_sink_pin3,
    // Outputs to the power stage
    output logic gate_drive,
    output logic [3:0] string_on,
    output logic [9:0] led_amplitude,
    output logic [7:0] regulation_level,
    output logic soft_start_active
);

    localparam int MIN_PULSE_CYC =
        (`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int MIN_ON_CYC =
        (`MIN_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam int RECIP =
        ((1024 << `RATIO_SHIFT) + DIM_PERIOD_CYC - 1) / DIM_PERIOD_CYC;

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Word index of a byte address; upper bits must be clear
    function automatic logic [8:0] word_index(input logic [11:0] a);
        word_index = {a[11:10] != 2'h0, a[9:2]};
    endfunction

    // Switching period in cycles for a frequency select code
    function automatic logic [10:0] fs_period(input logic [3:0] code);
        int khz;
        khz = `FS_MIN_KHZ + (int'(code) * (`FS_MAX_KHZ - `FS_MIN_KHZ))
            / `FS_STEPS;
        fs_period = 11'(`CLK_KHZ / khz);
    endfunction

    // High-time count of one dimming period to a 10-bit ratio
    function automatic level_t scale_ratio(input logic [12:0] hi);
        logic [31:0] p;
        p = 32'(hi) * 32'(RECIP);
        p = p >> `RATIO_SHIFT;
        scale_ratio = (p > 32'(`LEVEL_FULL)) ? `LEVEL_FULL : level_t'(p);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic aw_full_reg, w_full_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic w_strb0_reg;
    logic do_write;
    logic [1:0] method_reg;
    logic internal_reg;
    logic [3:0] strings_reg, freq_reg;
    level_t dim_reg;
    start_state_e state_reg;
    logic gate_reg;
    logic [3:0] string_on_reg;
    level_t meas_level_reg;

    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

    // Write address, data and response; address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
            aw_addr_reg <= 12'h000;
            w_data_reg <= 32'h00000000;
            w_strb0_reg <= 1'b0;
        end else begin
            awready_reg <= !aw_full_reg && !(awready_reg && awvalid)
                && !do_write;
            wready_reg <= !w_full_reg && !(wready_reg && wvalid)
                && !do_write;
            if (awready_reg && awvalid) begin
                aw_addr_reg <= awaddr;
                aw_full_reg <= 1'b1;
            end
            if (wready_reg && wvalid) begin
                w_data_reg <= wdata;
                w_strb0_reg <= wstrb[0];
                w_full_reg <= 1'b1;
            end
            if (do_write) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                unique case (word_index(aw_addr_reg))
                    {1'b0, `IDX_MODE}, {1'b0, `IDX_FREQ},
                    {1'b0, `IDX_DIM_LO}, {1'b0, `IDX_DIM_HI},
                    {1'b0, `IDX_STATUS}: bresp_reg <= `RESP_OKAY;
                    default: bresp_reg <= `RESP_SLVERR;
                endcase
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Register stores; only the low byte lane holds bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            method_reg <= `RST_METHOD;
            internal_reg <= `RST_INTERNAL;
            strings_reg <= `RST_STRINGS;
            freq_reg <= `RST_FREQ;
            dim_reg <= `RST_DIM;
        end else if (do_write && w_strb0_reg) begin
            unique case (word_index(aw_addr_reg))
                {1'b0, `IDX_MODE}: begin
                    method_reg <= w_data_reg[`MODE_METHOD_LSB +: 2];
                    internal_reg <= w_data_reg[`MODE_INTERNAL_BIT];
                    strings_reg <= w_data_reg[`MODE_STRING_LSB +: 4];
                end
                {1'b0, `IDX_FREQ}: freq_reg <= w_data_reg[`FREQ_SEL_LSB +: 4];
                {1'b0, `IDX_DIM_LO}: dim_reg[1:0] <= w_data_reg[1:0];
                {1'b0, `IDX_DIM_HI}: dim_reg[9:2] <= w_data_reg[7:0];
                default: ;
            endcase
        end
    end

    // Read channel, one cycle from address to data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `RESP_OKAY;
        end else begin
            arready_reg <= !rvalid_reg && !(arready_reg && arvalid);
            if (arready_reg && arvalid) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= 32'h00000000;
                rresp_reg <= `RESP_OKAY;
                unique case (word_index(araddr))
                    {1'b0, `IDX_MODE}: rdata_reg[7:0] <= {strings_reg,
                        1'b0, internal_reg, method_reg};
                    {1'b0, `IDX_FREQ}: rdata_reg[3:0] <= freq_reg;
                    {1'b0, `IDX_DIM_LO}: rdata_reg[1:0] <= dim_reg[1:0];
                    {1'b0, `IDX_DIM_HI}: rdata_reg[7:0] <= dim_reg[9:2];
                    {1'b0, `IDX_STATUS}: begin
                        rdata_reg[`STAT_STATE_LSB +: 3] <= state_reg;
                        rdata_reg[`STAT_GATE_BIT] <= gate_reg;
                        rdata_reg[`STAT_STRING_LSB +: 4] <= string_on_reg;
                        rdata_reg[`STAT_LEVEL_LSB +: 10] <= meas_level_reg;
                    end
                    default: rresp_reg <= `RESP_SLVERR;
                endcase
            end else if (rvalid_reg && rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Brightness input filter and measurement

    logic pwm_filt_reg;
    logic [7:0] glitch_cnt_reg;
    logic [12:0] dim_cnt_reg, high_cnt_reg;
    logic dim_wrap;

    assign dim_wrap = dim_cnt_reg == 13'(DIM_PERIOD_CYC - 1);

    // A change is taken only after it has stood for the minimum width
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_filt_reg <= 1'b0;
            glitch_cnt_reg <= 8'h00;
        end else if (pwm_in == pwm_filt_reg) begin
            glitch_cnt_reg <= 8'h00;
        end else if (glitch_cnt_reg == 8'(MIN_PULSE_CYC - 1)) begin
            pwm_filt_reg <= pwm_in;
            glitch_cnt_reg <= 8'h00;
        end else begin
            glitch_cnt_reg <= glitch_cnt_reg + 8'h01;
        end
    end

    // Period counter and high-time average over one dimming period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dim_cnt_reg <= 13'h0000;
            high_cnt_reg <= 13'h0000;
            meas_level_reg <= 10'h000;
        end else if (dim_wrap) begin
            dim_cnt_reg <= 13'h0000;
            high_cnt_reg <= 13'h0000;
            meas_level_reg <= scale_ratio(high_cnt_reg);
        end else begin
            dim_cnt_reg <= dim_cnt_reg + 13'h0001;
            high_cnt_reg <= high_cnt_reg + 13'(pwm_filt_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Settings applied at the period edge

    // Mid-period changes would chop a dimming pulse and flicker
    dim_method_e app_method_reg;
    logic app_internal_reg;
    level_t app_dim_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            app_method_reg <= METH_PWM;
            app_internal_reg <= `RST_INTERNAL;
            app_dim_reg <= `RST_DIM;
        end else if (dim_wrap) begin
            app_method_reg <= dim_method_e'(method_reg);
            app_internal_reg <= internal_reg;
            app_dim_reg <= dim_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start-up sequence

    logic [16:0] ss_cnt_reg;
    logic checks_clear, run_ok, ss_act_reg;
    assign checks_clear = !string_fault && !supply_undervoltage_lockout
        && !over_temp && !switch_overcurrent_protection;
    assign run_ok = state_reg == ST_SOFT_START || state_reg == ST_RUN;

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            state_reg <= ST_IDLE;
            ss_cnt_reg <= 17'h00000;
            ss_act_reg <= 1'b0;
        end else begin
            ss_act_reg <= state_reg == ST_SOFT_START;
            unique case (state_reg)
                ST_IDLE: state_reg <= ST_OVP_CHECK;
                ST_OVP_CHECK: if (output_overvoltage_sense) begin
                    state_reg <= ST_SAFETY;
                end
                ST_SAFETY: if (checks_clear) begin
                    state_reg <= ST_SOFT_START;
                    ss_cnt_reg <= 17'h00000;
                end
                ST_SOFT_START: begin
                    ss_cnt_reg <= ss_cnt_reg + 17'h00001;
                    if (ss_cnt_reg == 17'(SOFT_START_CYC - 1)) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: ;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dimming decision

    level_t level, amp_next;
    logic on_next, analog_region, mixed;
    level_t led_amp_reg;
    always_comb begin
        level = app_internal_reg ? app_dim_reg : meas_level_reg;
        mixed = app_method_reg == METH_MIX25 || app_method_reg == METH_MIX50;
        unique case (app_method_reg)
            METH_PWM: analog_region = 1'b0;
            METH_ANALOG: analog_region = 1'b1;
            METH_MIX25: analog_region = level > `LEVEL_MIX25;
            METH_MIX50: analog_region = level > `LEVEL_MIX50;
        endcase
        if (analog_region) begin
            amp_next = level;
            on_next = level >= `LEVEL_LOW_CUT;
        end else begin
            amp_next = `LEVEL_FULL;
            on_next = 26'(dim_cnt_reg) < ((26'(level) *
                26'(DIM_PERIOD_CYC)) >> 10);
            if (mixed && level < `LEVEL_LOW_CUT) begin
                on_next = 1'b0;
            end
            if (app_method_reg == METH_PWM && !app_internal_reg) begin
                on_next = pwm_in;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            string_on_reg <= 4'h0;
            led_amp_reg <= 10'h000;
        end else begin
            string_on_reg <= (run_ok && on_next) ? strings_reg : 4'h0;
            led_amp_reg <= run_ok ? amp_next : 10'h000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Boost switch timing

    logic [10:0] sw_cnt_reg, sw_period_reg;
    logic [4:0] on_cnt_reg;
    logic [7:0] reg_level_reg;
    logic min_done;
    assign min_done = on_cnt_reg >= 5'(MIN_ON_CYC - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_cnt_reg <= 11'h000;
            sw_period_reg <= fs_period(`RST_FREQ);
            gate_reg <= 1'b0;
            on_cnt_reg <= 5'h00;
        end else begin
            sw_cnt_reg <= sw_cnt_reg + 11'h001;
            if (gate_reg && !min_done) begin
                on_cnt_reg <= on_cnt_reg + 5'h01;
            end
            if (!run_ok) begin
                gate_reg <= 1'b0;
            end else if (sw_cnt_reg == 11'h000) begin
                gate_reg <= boost_request;
                on_cnt_reg <= 5'h00;
            end else if (gate_reg && min_done
                && (switch_current_sense || light_load)) begin
                gate_reg <= 1'b0;
            end
            if (sw_cnt_reg >= sw_period_reg - 11'h001) begin
                sw_cnt_reg <= 11'h000;
                sw_period_reg <= fs_period(freq_reg);
            end
        end
    end

    // Lowest enabled sink sets the loop target
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_level_reg <= 8'hff;
        end else begin
            reg_level_reg <= min_sink();
        end
    end

    function automatic logic [7:0] min_sink();
        logic [7:0] m;
        m = 8'hff;
        if (strings_reg[0] && string_sink_pin0 < m) m = string_sink_pin0;
        if (strings_reg[1] && string_sink_pin1 < m) m = string_sink_pin1;
        if (strings_reg[2] && string_sink_pin2 < m) m = string_sink_pin2;
        if (strings_reg[3] && string_sink_pin3 < m) m = string_sink_pin3;
        min_sink = m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign gate_drive = gate_reg;
    assign string_on = string_on_reg;
    assign led_amplitude = led_amp_reg;
    assign regulation_level = reg_level_reg;
    assign soft_start_active = ss_act_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_ext_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_RUN && app_method_reg == METH_PWM
        && !app_internal_reg && pwm_in |=> string_on_reg == strings_reg)
        else $error("string drive does not follow brightness pin");
    a_dim_period: assert property (@(posedge aclk) disable iff (!aresetn)
        dim_wrap |=> dim_cnt_reg == 13'h0000 ##1 dim_cnt_reg == 13'h0001)
        else $error("dimming period counter wrong");
    a_mixed_full: assert property (@(posedge aclk) disable iff (!aresetn)
        run_ok && mixed && !analog_region |=> led_amp_reg == `LEVEL_FULL)
        else $error("mixed duty region amplitude not full");
    a_analog_amp: assert property (@(posedge aclk) disable iff (!aresetn)
        run_ok && app_method_reg == METH_ANALOG
        |=> led_amp_reg == $past(level))
        else $error("analog amplitude not equal to level");
    a_low_cut: assert property (@(posedge aclk) disable iff (!aresetn)
        analog_region && level < `LEVEL_LOW_CUT |=> string_on_reg == 4'h0)
        else $error("strings on below low cut");
    a_pulse_filter: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(pwm_filt_reg)
        |-> $past(glitch_cnt_reg) == 8'(MIN_PULSE_CYC - 1))
        else $error("short pulse passed the filter");
    a_ovp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && state_reg == ST_OVP_CHECK && !output_overvoltage_sense
        |=> state_reg == ST_OVP_CHECK && !gate_reg)
        else $error("left overvoltage check without sense");
    a_safety_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && state_reg == ST_SAFETY && !checks_clear
        |=> state_reg == ST_SAFETY)
        else $error("soft start despite failed check");
    a_min_on: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(gate_reg) && $past(run_ok) && $past(sw_cnt_reg) != 11'h000
        |-> $past(min_done))
        else $error("switch on time below minimum");
    a_off_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
        !run_ok |=> string_on_reg == 4'h0 && !gate_reg)
        else $error("outputs active while inhibited");

endmodule // led_dimming_mode_control

// ---- testbench/pwm_host.sv ----
/*
 Host model driving the brightness pin.
 Assumes high and low lengths given in aclk cycles.
*/
`timescale 1ns/1ns
module pwm_host (
    // Clock and pattern
    input wire logic aclk,
    input wire logic [15:0] hi_cyc,
    input wire logic [15:0] lo_cyc,
    // Brightness pin
    output logic pwm_in
);
    logic [15:0] n = '0;
    // Period counter; a new length takes effect at once
    always_ff @(posedge aclk) begin
        n <= (n + 16'h1 >= hi_cyc + lo_cyc) ? '0 : n + 16'h1;
    end
    // Pin follows the counter, so it is defined from time zero
    assign pwm_in = n < hi_cyc;
endmodule // pwm_host

// ---- testbench/led_dimming_mode_control_bench.sv ----
/*
 Bench for the LED dimming block: bus tasks and ordered tests.
 Assumes the pwm_host model on the brightness pin.
*/
`timescale 1ns/1ns
`include "led_dim_map.svh"
module led_dimming_mode_control_bench;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
    logic arvalid = '0, rready = '0, enable = '0, light_load = '0;
    logic output_overvoltage_sense = '0, switch_current_sense = '0;
    logic boost_request = '0, pwm_in, awready, wready, bvalid, arready;
    logic rvalid, gate_drive, soft_start_active;
    logic [3:0] f = '0, ws = '1, string_on;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, sk = 32'h05141e28;
    logic [15:0] hi = '0, lo = 16'h1;
    logic [1:0] bresp, rresp;
    logic [9:0] led_amplitude;
    logic [7:0] regulation_level;
    int failures = 0, n_checks = 0, w, p;
    // Rows: mode, dim, amplitude (0 = not checked), on cycles per period
    logic [43:0] tbl [8] = '{
        44'hf4_200_3ff_3e8,
        44'hf5_200_200_7d0,
        44'hf5_00c_000_000,
        44'hf5_00d_00d_7d0,
        44'hf6_100_3ff_1f4,
        44'hf6_101_101_7d0,
        44'hf7_300_300_7d0,
        44'hf7_200_3ff_3e8};
    led_dimming_mode_control #(.DIM_PERIOD_CYC(2000), .SOFT_START_CYC(20))
        led_dimming_mode_control_inst (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb(ws), .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .enable, .pwm_in, .output_overvoltage_sense,
        .string_fault(f[0]), .supply_undervoltage_lockout(f[1]),
        .over_temp(f[2]), .switch_overcurrent_protection(f[3]),
        .switch_current_sense, .light_load, .boost_request,
        .string_sink_pin0(sk[7:0]), .string_sink_pin1(sk[15:8]),
        .string_sink_pin2(sk[23:16]), .string_sink_pin3(sk[31:24]),
        .gate_drive, .string_on, .led_amplitude, .regulation_level,
        .soft_start_active);
    pwm_host pwm_host_inst (.aclk, .hi_cyc(hi), .lo_cyc(lo), .pwm_in);
    always #4 aclk = ~aclk;
////////////////////////////////////////
    task automatic chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit ta, tw;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            ta |= awready;
            tw |= wready;
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        @(posedge aclk iff bvalid);
        bready <= 1'b0;
        chk(bresp, `RESP_OKAY);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
        input logic [1:0] r = `RESP_OKAY, input logic [31:0] m = '1);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk iff arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        @(posedge aclk iff rvalid);
        rready <= 1'b0;
        chk(rdata & m, e);
        chk(rresp, r);
    endtask
    // High cycles of the gate or of the first string over n cycles
    task automatic cnt(input int n, input bit g, output int c);
        c = 0;
        repeat (n) begin
            @(posedge aclk);
            c += g ? gate_drive : string_on[0];
        end
    endtask
    // Gate pulse width w; p is one more than the switching period
    task automatic meas;
        @(posedge aclk iff !gate_drive);
        @(posedge aclk iff gate_drive);
        w = 1;
        p = 1;
        while (p == w || !gate_drive) begin
            @(posedge aclk);
            if (gate_drive && p == w) w++;
            p++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(12'h000, 32'hf0);
        rd(12'h004, 32'h0);
        rd(12'h00c, 32'h3);
        rd(12'h010, 32'hff);
        rd(12'h008, 32'h0, `RESP_SLVERR);
        rd(12'h01c, 32'h0, `RESP_OKAY, 32'hff);
        f <= 4'h1;
        enable <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(12'h01c, 32'h1, `RESP_OKAY, 32'hff);
        output_overvoltage_sense <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            f <= 4'h1 << i;
            repeat (20) @(posedge aclk);
            rd(12'h01c, 32'h2, `RESP_OKAY, 32'hff);
        end
        f <= 4'h0;
        repeat (5) @(posedge aclk);
        #1;
        chk(soft_start_active, 1'b1);
        repeat (40) @(posedge aclk);
        rd(12'h01c, 32'h4, `RESP_OKAY, 32'h7);
        $display("test start-up done");
        hi <= 16'h12c;
        lo <= 16'h12c;
        repeat (1000) @(posedge aclk);
        cnt(600, 0, w);
        chk(w, 300);
        chk(regulation_level, 8'h05);
        boost_request <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(12'h004, i * 15);
            switch_current_sense <= !i[0];
            light_load <= i[0];
            meas;
            meas;
            chk(w >= 19, 1'b1);
            chk(p - 1, 125000 / (100 + i * 800));
        end
        boost_request <= 1'b0;
        repeat (300) @(posedge aclk);
        cnt(300, 1, w);
        chk(w, 0);
        $display("test switching done");
        foreach (tbl[i]) begin
            wr(12'h000, tbl[i][43:36]);
            wr(12'h00c, tbl[i][25:24]);
            wr(12'h010, tbl[i][33:26]);
            repeat (4000) @(posedge aclk);
            cnt(2000, 0, w);
            chk(w, tbl[i][11:0]);
            chk(tbl[i][23:12] ? led_amplitude : 12'h0, tbl[i][23:12]);
        end
        $display("test internal dimming done");
        wr(12'h000, 32'hf1);
        hi <= 16'h3e8;
        lo <= 16'h3e8;
        repeat (6000) @(posedge aclk);
        chk(led_amplitude, 10'h200);
        hi <= 16'h64;
        lo <= 16'h76c;
        repeat (6000) @(posedge aclk);
        cnt(2000, 0, w);
        chk(w, 0);
        sk[7:0] <= 8'h10;
        wr(12'h000, 32'h72);
        hi <= 16'h1f4;
        lo <= 16'h5dc;
        repeat (6000) @(posedge aclk);
        cnt(2000, 0, w);
        chk(w, 500);
        chk(led_amplitude, 10'h3ff);
        chk(regulation_level, 8'h10);
        rd(12'h000, 32'h72);
        ws <= 4'he;
        wr(12'h000, 32'hf4);
        rd(12'h000, 32'h72);
        $display("test external dimming done");
        wrap_up;
    end
    // Watchdog sized above the length of all tests
    initial begin
        repeat (95000) @(posedge aclk);
        failures++;
        wrap_up;
    end
endmodule // led_dimming_mode_control_bench
